/* File: design/i2cc_pkg.sv */
// package: register map, fields, resets and state codes
package i2cc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_MTX   = 12'h000; // master tx byte, starts a frame
  localparam logic [11:0] OFF_STAT  = 12'h004; // engine status
  localparam logic [11:0] OFF_ISTAT = 12'h008; // sticky events, write one to clear
  localparam logic [11:0] OFF_IMASK = 12'h00C; // event mask
  localparam logic [11:0] OFF_SRX   = 12'h010; // last byte taken by the slave
  localparam logic [11:0] OFF_CTRL  = 12'h028; // control bits
  localparam logic [11:0] OFF_DIV   = 12'h030; // scl high/low counts
  localparam logic [11:0] OFF_ALT   = 12'h034; // alt_hw_call_address
  localparam logic [11:0] OFF_ID0   = 12'h038; // slave_match_address_0, 1..3 follow
  localparam logic [11:0] ID_STEP   = 12'h004; // spacing of the match addresses
  // ------------------------------------------------------------
  // control bit positions
  // ------------------------------------------------------------
  localparam int CB_SEN   = 0; // slave enable
  localparam int CB_MEN   = 1; // master enable
  localparam int CB_GCEN  = 3; // general call enable
  localparam int CB_HWGC  = 4; // hardware general call enable
  localparam int CB_NOBO  = 5; // start backoff disable
  localparam int CB_LOOP  = 6; // loopback
  localparam int CB_MCLK  = 7; // master serial clock enable
  localparam int CB_GCCLR = 8; // general call status clear
  localparam int CTRL_W   = 9;
  // ------------------------------------------------------------
  // event bit positions
  // ------------------------------------------------------------
  localparam int IB_GC    = 0; // general call seen
  localparam int IB_HWGC  = 1; // hardware general call matched
  localparam int IB_MDONE = 2; // master frame finished
  localparam int IB_ARB   = 3; // arbitration lost
  localparam int IB_SADR  = 4; // own slave address matched
  localparam int INT_W    = 5;
  // ------------------------------------------------------------
  // reset values, codes and counts
  // ------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [15:0] DIV_RST   = 16'h1F1F; // [15:8] high, [7:0] low count
  localparam logic [7:0]  ADR_RST   = 8'h00;    // ids and alt address
  localparam logic [7:0]  GC_ADDR   = 8'h00;    // general call address byte
  localparam logic [7:0]  GC_RESET  = 8'h06;    // reset command byte
  localparam logic [7:0]  GC_REPROG = 8'h04;    // reprogram address command byte
  localparam logic [1:0]  GCC_NONE  = 2'h0;
  localparam logic [1:0]  GCC_RST   = 2'h1;
  localparam logic [1:0]  GCC_PROG  = 2'h2;
  localparam logic [1:0]  GCC_HW    = 2'h3;
  localparam logic [7:0]  BACKOFF_TICKS = 8'h10; // scl half periods after idle
  localparam logic [3:0]  ACK_BIT   = 4'h8;      // bit index of the ack slot
  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    M_IDLE = 7'h01, M_WAIT = 7'h02, M_START = 7'h04, M_LOW = 7'h08,
    M_HIGH = 7'h10, M_STOP1 = 7'h20, M_STOP2 = 7'h40
  } i2cc_mst_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_ADDR = 5'h02, S_ACK = 5'h04, S_DATA = 5'h08, S_SKIP = 5'h10
  } i2cc_slv_t;
endpackage

/* File: design/i2cc_line_if.sv */
// interface: bus line levels and events from the line watcher to the engines
`timescale 1ns/1ps
`default_nettype none
interface i2cc_line_if;
  logic scl;      // line level seen by the engines
  logic sda;      // line level seen by the engines
  logic start;    // start condition, one cycle
  logic stop;     // stop condition, one cycle
  logic rise;     // scl rising edge, one cycle
  logic fall;     // scl falling edge, one cycle
  logic busy;     // between start and stop
  logic loop;     // loopback select
  logic drv_scl;  // block pulls scl low
  logic drv_sda;  // block pulls sda low
  modport src (output scl, sda, start, stop, rise, fall, busy, input loop, drv_scl, drv_sda);
  modport snk (input scl, sda, start, stop, rise, fall, busy, output loop, drv_scl, drv_sda);
endinterface
`default_nettype wire

/* File: design/i2cc_line_watch.sv */
// module: pin synchroniser, loopback select and start/stop/edge detection
`timescale 1ns/1ps
`default_nettype none
module i2cc_line_watch (
  input  wire logic pclk,     // core clock
  input  wire logic presetn,  // async reset, low
  input  wire logic scl_i,    // scl pin level
  input  wire logic sda_i,    // sda pin level
  i2cc_line_if.src  ln        // levels and events
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] s1;   // first sync stage, read only by s2
    logic [1:0] s2;   // second sync stage
    logic [1:0] prev; // last level seen, {scl, sda}
    logic       busy; // bus held by some master
  } i2cc_watch_t;
  i2cc_watch_t st_reg, st_next;
  logic [1:0] cur;    // level used this cycle
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // loopback takes the block's own drive and ignores the pins
  always_comb begin
    cur = ln.loop ? {~ln.drv_scl, ~ln.drv_sda} : st_reg.s2;
    st_next = st_reg;
    st_next.s1 = {scl_i, sda_i};
    st_next.s2 = st_reg.s1;
    st_next.prev = cur;
    if (ln.start) begin
      st_next.busy = 1'b1;
    end else if (ln.stop) begin
      st_next.busy = 1'b0;
    end
  end
  // events compare with the previous level, never with s1
  assign ln.scl = cur[1];
  assign ln.sda = cur[0];
  assign ln.start = st_reg.prev[1] & cur[1] & st_reg.prev[0] & ~cur[0];
  assign ln.stop = st_reg.prev[1] & cur[1] & ~st_reg.prev[0] & cur[0];
  assign ln.rise = ~st_reg.prev[1] & cur[1];
  assign ln.fall = st_reg.prev[1] & ~cur[1];
  assign ln.busy = st_reg.busy;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // idle bus reads high, so lines start released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{s1: 2'h3, s2: 2'h3, prev: 2'h3, busy: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

/* File: design/i2cc_ctrl.sv */
// module: i2c master/slave control bits, general call handling, apb registers
//
// Functional notes
// - gc clear bit clears status and itself in the same cycle
// - scl generated only while clock enable set
// - loopback routes transmit into receive internally
// - backoff disabled retries at once, else waits
// - hw general call compares data with alt
// - gc enable acks address zero and data
// - reset command byte resets serial interface
// - every general call sets gc status bit while gc enable set
// - master channel runs only while enabled
// - slave enable watches four match addresses
// - match addresses reset zero, read/write
`timescale 1ns/1ps
`default_nettype none
module i2cc_ctrl
  import i2cc_pkg::*;
(
  input  wire logic        pclk,     // core clock, 40 MHz
  input  wire logic        presetn,  // async reset, low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error, unmapped
  input  wire logic        scl_i,    // scl pin level
  output logic             scl_o,    // scl drive level, always low
  output logic             scl_oe,   // scl pulled low
  input  wire logic        sda_i,    // sda pin level
  output logic             sda_o,    // sda drive level, always low
  output logic             sda_oe,   // sda pulled low
  output logic             irq       // level interrupt
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;     // control bits
    logic [7:0]        alt;      // alternate hw call address
    logic [3:0][7:0]   id;       // slave match addresses
    logic [15:0]       div;      // scl counts
    logic [INT_W-1:0]  ist;      // sticky events
    logic [INT_W-1:0]  imask;    // event mask
    logic [1:0]        gc_code;  // last general call kind
    logic [7:0]        srx;      // last received byte
    logic [7:0]        mtx;      // master byte
    logic              go;       // master frame pending
    logic              nack;     // last master frame not acked
    logic [31:0]       prdata;   // bus read data
    logic              pready;   // bus ready
    logic              pslverr;  // bus error
    logic              irq;      // interrupt
    i2cc_mst_t         mst;      // master state
    logic [7:0]        msh;      // master shifter
    logic [3:0]        mbit;     // master bit index
    logic [7:0]        mdiv;     // tick divider
    logic [7:0]        mboff;    // backoff ticks left
    logic              m_scl;    // master pulls scl
    logic              m_sda;    // master pulls sda
    i2cc_slv_t         slv;      // slave state
    logic [7:0]        ssh;      // slave shifter
    logic [3:0]        sbit;     // slave bit count
    logic              s_gc;     // frame is a general call
    logic              s_rd;     // frame is a read
    logic              s_rst;    // reset after this ack
    logic              s_sda;    // slave pulls sda
    logic              scl_oe;   // pin enables
    logic              sda_oe;
    logic              pin_lvl;  // open drain level, held low
  } i2cc_state_t;
  i2cc_state_t st_reg, st_next;
  i2cc_line_if ln ();
  logic       tick;     // one scl half period elapsed
  logic       acc;      // apb access phase
  logic       wr;       // write takes effect
  logic [3:0] id_hit;   // address decodes one id
  logic [3:0] id_match; // received address equals id
  logic [INT_W-1:0] ev; // events this cycle
  logic       mapped;   // address decodes
  logic [31:0] rdata;   // read mux
  // ------------------------------------------------------------
  // line watcher
  // ------------------------------------------------------------
  i2cc_line_watch u_watch (
    .pclk    (pclk),
    .presetn (presetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .ln      (ln)
  );
  assign ln.loop = st_reg.ctrl[CB_LOOP];
  assign ln.drv_scl = st_reg.m_scl;
  assign ln.drv_sda = st_reg.m_sda | st_reg.s_sda;
  // ------------------------------------------------------------
  // per id decode and match
  // ------------------------------------------------------------
  // address bits 7:1 carry the 7-bit address, bit 0 the direction
  for (genvar i = 0; i < 4; i++) begin : g_id
    assign id_hit[i] = paddr == OFF_ID0 + ID_STEP * 12'(i);
    assign id_match[i] = st_reg.ssh[7:1] == st_reg.id[i][7:1];
  end
  assign acc = psel & penable & st_reg.pready;
  assign wr = acc & pwrite;
  assign tick = st_reg.mdiv == 8'h00;
  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      OFF_MTX:   rdata[7:0] = st_reg.mtx;
      OFF_STAT:  rdata[4:0] = {ln.busy, st_reg.nack, st_reg.go, st_reg.gc_code};
      OFF_ISTAT: rdata[INT_W-1:0] = st_reg.ist;
      OFF_IMASK: rdata[INT_W-1:0] = st_reg.imask;
      OFF_SRX:   rdata[7:0] = st_reg.srx;
      OFF_CTRL:  rdata[CTRL_W-1:0] = st_reg.ctrl;
      OFF_DIV:   rdata[15:0] = st_reg.div;
      OFF_ALT:   rdata[7:0] = st_reg.alt;
      default: begin
        mapped = |id_hit;
        for (int i = 0; i < 4; i++) begin
          if (id_hit[i]) begin
            rdata[7:0] = st_reg.id[i];
          end
        end
      end
    endcase
  end
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    ev = '0;
    // apb: answer one cycle after setup, write at the ready edge
    st_next.pready = psel & ~penable;
    st_next.pslverr = psel & ~penable & ~mapped;
    if (psel & ~penable) begin
      st_next.prdata = rdata;
    end
    // gc clear acts the cycle after it was written, then drops
    if (st_reg.ctrl[CB_GCCLR]) begin
      st_next.ctrl[CB_GCCLR] = 1'b0;
      st_next.gc_code = GCC_NONE;
      st_next.ist[IB_GC] = 1'b0;
      st_next.ist[IB_HWGC] = 1'b0;
    end
    if (wr & mapped & ~st_reg.pslverr) begin
      case (paddr)
        OFF_MTX: begin
          if (!st_reg.go) begin
            st_next.mtx = pwdata[7:0];
            st_next.go = 1'b1;
            st_next.nack = 1'b0;
          end
        end
        OFF_ISTAT: st_next.ist = st_next.ist & ~pwdata[INT_W-1:0];
        OFF_IMASK: st_next.imask = pwdata[INT_W-1:0];
        OFF_CTRL:  st_next.ctrl = pwdata[CTRL_W-1:0];
        OFF_DIV:   st_next.div = pwdata[15:0];
        OFF_ALT:   st_next.alt = pwdata[7:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (id_hit[i]) begin
              st_next.id[i] = pwdata[7:0];
            end
          end
        end
      endcase
    end
    // -- master: divider runs only with both enables, stretch holds it
    if (st_reg.ctrl[CB_MEN] & st_reg.ctrl[CB_MCLK]) begin
      if (tick) begin
        st_next.mdiv = st_reg.m_scl ? st_reg.div[15:8] : st_reg.div[7:0];
      end else if (!(st_reg.mst == M_HIGH && !ln.scl)) begin
        st_next.mdiv = st_reg.mdiv - 8'h01;
      end
    end
    case (st_reg.mst)
      M_IDLE: begin
        if (st_reg.go & st_reg.ctrl[CB_MEN] & st_reg.ctrl[CB_MCLK] & ~ln.busy) begin
          st_next.mst = M_START;
          st_next.m_sda = 1'b1;
          st_next.msh = st_reg.mtx;
          st_next.mdiv = st_reg.div[7:0];
        end
      end
      M_WAIT: begin
        // backoff counts only once the bus is idle
        if (!ln.busy) begin
          if (st_reg.mboff == 8'h00) begin
            st_next.mst = M_IDLE;
          end else if (tick & st_reg.ctrl[CB_MCLK]) begin
            st_next.mboff = st_reg.mboff - 8'h01;
          end
        end
      end
      M_START: begin
        if (tick & st_reg.ctrl[CB_MCLK]) begin
          st_next.mst = M_LOW;
          st_next.m_scl = 1'b1;
          st_next.mbit = 4'h0;
          st_next.m_sda = ~st_reg.msh[7];
        end
      end
      M_LOW: begin
        if (tick & st_reg.ctrl[CB_MCLK]) begin
          st_next.mst = M_HIGH;
          st_next.m_scl = 1'b0;
        end
      end
      M_HIGH: begin
        if (tick & st_reg.ctrl[CB_MCLK] & ln.scl) begin
          if (st_reg.mbit == ACK_BIT) begin
            st_next.nack = ln.sda;
            st_next.mst = M_STOP1;
            st_next.m_scl = 1'b1;
            st_next.m_sda = 1'b1;
          end else if (!st_reg.m_sda && !ln.sda) begin
            // lost: release both lines and get off the bus
            st_next.mst = M_WAIT;
            st_next.m_scl = 1'b0;
            st_next.m_sda = 1'b0;
            st_next.mboff = st_reg.ctrl[CB_NOBO] ? 8'h00 : BACKOFF_TICKS;
            ev[IB_ARB] = 1'b1;
          end else begin
            st_next.mst = M_LOW;
            st_next.m_scl = 1'b1;
            st_next.mbit = st_reg.mbit + 4'h1;
            st_next.msh = {st_reg.msh[6:0], 1'b0};
            st_next.m_sda = (st_reg.mbit == ACK_BIT - 4'h1) ? 1'b0 : ~st_reg.msh[6];
          end
        end
      end
      M_STOP1: begin
        if (tick & st_reg.ctrl[CB_MCLK]) begin
          st_next.mst = M_STOP2;
          st_next.m_scl = 1'b0;
        end
      end
      M_STOP2: begin
        if (tick & st_reg.ctrl[CB_MCLK]) begin
          st_next.mst = M_IDLE;
          st_next.m_sda = 1'b0;
          st_next.go = 1'b0;
          ev[IB_MDONE] = 1'b1;
        end
      end
      default: st_next.mst = M_IDLE;
    endcase
    // disabling the master abandons the frame in flight and frees the lines; go stays set, so it restarts
    if (!st_reg.ctrl[CB_MEN]) begin
      st_next.mst = M_IDLE;
      st_next.m_scl = 1'b0;
      st_next.m_sda = 1'b0;
    end
    // -- slave: sample on scl rise, act on scl fall
    if (ln.rise) begin
      st_next.ssh = {st_reg.ssh[6:0], ln.sda};
      st_next.sbit = st_reg.sbit + 4'h1;
    end
    case (st_reg.slv)
      S_ADDR: begin
        if (ln.fall && st_reg.sbit == ACK_BIT) begin
          st_next.sbit = 4'h0;
          if (st_reg.ssh == GC_ADDR && st_reg.ctrl[CB_GCEN]) begin
            st_next.slv = S_ACK;
            st_next.s_sda = 1'b1;
            st_next.s_gc = 1'b1;
            st_next.s_rd = 1'b0;
            ev[IB_GC] = 1'b1;
          end else if (st_reg.ctrl[CB_SEN] && |id_match && st_reg.ssh != GC_ADDR) begin
            st_next.slv = S_ACK;
            st_next.s_sda = 1'b1;
            st_next.s_gc = 1'b0;
            st_next.s_rd = st_reg.ssh[0];
            ev[IB_SADR] = 1'b1;
          end else begin
            st_next.slv = S_SKIP;
          end
        end
      end
      S_ACK: begin
        if (ln.fall) begin
          st_next.s_sda = 1'b0;
          st_next.sbit = 4'h0;
          // no tx path: reads are released
          st_next.slv = st_reg.s_rd ? S_SKIP : S_DATA;
        end
      end
      S_DATA: begin
        if (ln.fall && st_reg.sbit == ACK_BIT) begin
          st_next.srx = st_reg.ssh;
          st_next.slv = S_ACK;
          st_next.s_sda = 1'b1;
          st_next.sbit = 4'h0;
          if (st_reg.s_gc) begin
            if (st_reg.ssh == GC_RESET) begin
              st_next.gc_code = GCC_RST;
              st_next.s_rst = 1'b1;
            end else if (st_reg.ssh == GC_REPROG) begin
              st_next.gc_code = GCC_PROG;
            end
            if (st_reg.ctrl[CB_HWGC] & st_reg.ctrl[CB_GCEN] & (st_reg.ssh == st_reg.alt)) begin
              st_next.gc_code = GCC_HW;
              ev[IB_HWGC] = 1'b1;
            end
          end
        end
      end
      S_IDLE, S_SKIP: begin
        st_next.s_sda = 1'b0;
      end
      default: st_next.slv = S_IDLE;
    endcase
    if (ln.stop) begin
      st_next.slv = S_IDLE;
      st_next.s_sda = 1'b0;
    end else if (ln.start) begin
      st_next.slv = S_ADDR;
      st_next.sbit = 4'h0;
      st_next.s_sda = 1'b0;
    end
    // reset command acts once its ack slot has ended
    if (st_reg.s_rst && st_reg.slv == S_ACK && ln.fall) begin
      st_next.ctrl = CTRL_RST;
      st_next.go = 1'b0;
      st_next.mst = M_IDLE;
      st_next.m_scl = 1'b0;
      st_next.m_sda = 1'b0;
      st_next.slv = S_IDLE;
      st_next.s_rst = 1'b0;
    end
    // events win over any clear in the same cycle
    st_next.ist = st_next.ist | ev;
    st_next.irq = |(st_next.ist & st_next.imask);
    st_next.scl_oe = st_next.m_scl & ~st_next.ctrl[CB_LOOP];
    st_next.sda_oe = (st_next.m_sda | st_next.s_sda) & ~st_next.ctrl[CB_LOOP];
    st_next.pin_lvl = 1'b0;
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.div <= DIV_RST;
      st_reg.alt <= ADR_RST;
      st_reg.id <= {4{ADR_RST}};
      st_reg.mst <= M_IDLE;
      st_reg.slv <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign scl_oe = st_reg.scl_oe;
  assign sda_oe = st_reg.sda_oe;
  assign scl_o = st_reg.pin_lvl;
  assign sda_o = st_reg.pin_lvl;
endmodule
`default_nettype wire

/* File: verif/i2cc_ctrl_chk.sv */
// checker: port assertions
`timescale 1ns/1ps
`default_nettype none
module i2cc_ctrl_chk
  import i2cc_pkg::*;
(
  input wire logic        pclk,    // core clock
  input wire logic        presetn, // async reset, low
  input wire logic        psel,    // apb select
  input wire logic        penable, // apb access
  input wire logic        pwrite,  // apb direction
  input wire logic [11:0] paddr,   // apb address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic        pready,  // apb ready
  input wire logic        pslverr, // apb error
  input wire logic        scl_o,   // scl level
  input wire logic        scl_oe,  // scl pull
  input wire logic        sda_o,   // sda level
  input wire logic        sda_oe   // sda pull
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [CTRL_W-1:0] ctrl_reg; // last written control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_reg <= CTRL_RST;
    else if (psel && penable && pready && pwrite && paddr == OFF_CTRL)
      ctrl_reg <= pwdata[CTRL_W-1:0];
  end
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_answer; pready ##1 !pready; endsequence
  AST_APB_ANSWER: assert property (apb_setup |=> apb_answer) else $error("apb answer");
  AST_READY_QUAL: assert property (pready |-> psel && penable) else $error("ready outside access");
  AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("error without ready");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o) else $error("pin level not low");
  AST_LOOP_QUIET: assert property (ctrl_reg[CB_LOOP] [*2] |-> !scl_oe && !sda_oe)
    else $error("pins driven in loopback");
  AST_MST_OFF: assert property (!ctrl_reg[CB_MEN] [*3] |-> !scl_oe)
    else $error("scl pulled, master off");
  AST_CLK_HOLD: assert property (!ctrl_reg[CB_MCLK] [*2] |-> $stable(scl_oe))
    else $error("scl moved, clock off");
  AST_RST_QUIET: assert property ($rose(presetn) |-> !pready && !scl_oe && !sda_oe) else $error("busy after reset");
endmodule
bind i2cc_ctrl i2cc_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

/* File: verif/i2cc_bus_model.sv */
// partner: behavioural bus master on the far side of the slave pins
`timescale 1ns/1ps
`default_nettype none
module i2cc_bus_model (
  input  wire logic clk,      // pacing clock, 8 cycles a bit
  input  wire logic sda_line, // resolved sda
  output logic      scl,      // pull-up high
  output logic      sda       // pull-up high
);
  initial scl = 1'b1;
  initial sda = 1'b1;
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start, address, data, stop; msb first
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [1:0] ack);
    logic [15:0] s;
    s = {a, d};
    sda <= 1'b0;
    w(4);
    for (int i = 0; i < 18; i++) begin
      scl <= 1'b0;
      w(1);
      sda <= (i == 8 || i == 17) ? 1'b1 : s[15 - i + int'(i > 8)];
      w(3);
      scl <= 1'b1;
      w(2);
      if (i == 8 || i == 17)
        ack = {ack[0], !sda_line}; // low is ack
      w(2);
    end
    scl <= 1'b0;
    w(1);
    sda <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1; // stop, lines idle
    w(4);
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// testbench: apb and bus frame checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import i2cc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // clock, reset, apb
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0, prdata, q, alt; // apb data, read, alt
  logic [31:0] seed = 32'd69546; // xorshift state
  logic        pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, err; // outputs
  logic [1:0]  ack; // acks
  logic [7:0]  b; // byte
  int          error_cnt = 0, cmp_count = 0, cyc = 0; // counters
  wire logic   scl_i = m_scl & ~scl_oe; // wired-and lines
  wire logic   sda_i = m_sda & ~sda_oe;
  i2cc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  i2cc_bus_model pm_u (.clk(pclk), .sda_line(sda_i), .scl(m_scl), .sda(m_sda));
  always #12.5 pclk = ~pclk;
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang limit, far above the run's length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected gc code
  function automatic logic [1:0] gc_code(input logic [7:0] d);
    if (d == GC_RESET) return GCC_RST;
    if (d == GC_REPROG) return GCC_PROG;
    return (d == alt[7:0]) ? GCC_HW : GCC_NONE;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready; only the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  task automatic waitb(input logic [31:0] m);
    int n = 0;
    do apb(1'b0, OFF_ISTAT, 32'h0); while ((q & m) == 0 && n++ < 400);
    chk(q & m, m);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_CTRL, '1, 32'h0);
    rdc(OFF_DIV, '1, 32'h1F1F);
    rdc(OFF_ALT, '1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      b = 8'(xs());
      rdc(OFF_ID0 + 12'(4 * i), '1, 32'h0);
      apb(1'b1, OFF_ID0 + 12'(4 * i), {24'h0, b});
      rdc(OFF_ID0 + 12'(4 * i), '1, {24'h0, b});
    end
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("register test done");
    apb(1'b1, OFF_IMASK, 32'h1F);
    alt = xs() | 32'h1;
    apb(1'b1, OFF_ALT, {24'h0, alt[7:0]});
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? alt[7:0] : (k == 1) ? GC_REPROG : (k == 2) ? ((8'(xs()) & 8'hF0) | 8'h08) : GC_RESET;
      apb(1'b1, OFF_CTRL, 32'h019);
      pm_u.frame(GC_ADDR, b, ack);
      chk(ack, 2'b11);
      rdc(OFF_STAT, 32'h3, gc_code(b));
      rdc(OFF_ISTAT, 32'h3, {gc_code(b) == GCC_HW, 1'b1});
      chk(irq, 1'b1);
      if (b == GC_RESET) rdc(OFF_CTRL, '1, 32'h0);
      apb(1'b1, OFF_IMASK, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h119);
      chk(irq, 1'b0);
      rdc(OFF_CTRL, '1, 32'h019);
      rdc(OFF_STAT, 32'h3, 32'h0);
      rdc(OFF_ISTAT, 32'h3, 32'h0);
      apb(1'b1, OFF_IMASK, 32'h1F);
    end
    $display("general call test done");
    apb(1'b1, OFF_CTRL, 32'h0);
    pm_u.frame(GC_ADDR, 8'h55, ack);
    chk(ack[1], 1'b0);
    b = (8'(xs()) | 8'h10) & 8'hFE;
    apb(1'b1, OFF_ID0 + 12'h8, {24'h0, b});
    pm_u.frame(b, 8'h3C, ack);
    chk(ack[1], 1'b0);
    apb(1'b1, OFF_CTRL, 32'h001);
    pm_u.frame(b, 8'h3C, ack);
    chk(ack, 2'b11);
    rdc(OFF_ISTAT, 32'h10, 32'h10);
    $display("slave address test done");
    apb(1'b1, OFF_DIV, 32'h0303);
    apb(1'b1, OFF_ISTAT, 32'h1F);
    apb(1'b1, OFF_CTRL, 32'h002);
    apb(1'b1, OFF_MTX, xs() & 32'hFF);
    repeat (200) @(posedge pclk);
    rdc(OFF_ISTAT, 32'h4, 32'h0);
    rdc(OFF_STAT, 32'h4, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h082);
    waitb(32'h4);
    rdc(OFF_STAT, 32'hC, 32'h8);
    $display("master test done");
    apb(1'b1, OFF_ISTAT, 32'h1F);
    apb(1'b1, OFF_CTRL, 32'h0C2);
    apb(1'b1, OFF_MTX, xs() & 32'hFF);
    waitb(32'h4);
    $display("loopback test done");
    end_sim();
  end
endmodule
`default_nettype wire
